/* File: adfs_chk.sv */
// Purpose : Port timing checks for the frame serial control block.
// Assumes : Link pins reach the design through two sync flops.
// Notes   : Windows allow a few clocks of synchroniser lag.
`timescale 1ns/1ps
module adfs_chk #(
  parameter int CONV_CYCLES = 147
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            serial_clk_i,
  input wire logic            chip_sel_n_i,
  input wire logic            frame_sync_input_i,
  input wire logic            serial_data_out_o,
  input wire logic            serial_data_out_oe_n_o,
  input wire logic            power_down_o,
  input wire adfs_pkg::adfs_state_t state_o
);
  import adfs_pkg::*;
  // ****************
  // Edge and conversion counters
  // ****************
  logic        sck_q;
  logic [5:0]  fall_cnt;
  logic [5:0]  rise_cnt;
  logic [3:0]  rise_age;
  logic [15:0] conv_cnt;
  // Raw link edges are counted only while shifting, so each frame starts clean.
  always_ff @(posedge clk_i) begin
    sck_q <= serial_clk_i;
    if (rst_i || state_o != ADFS_ST_SHIFT) begin
      fall_cnt <= '0;
      rise_cnt <= '0;
    end else begin
      fall_cnt <= fall_cnt + 6'(sck_q & ~serial_clk_i);
      rise_cnt <= rise_cnt + 6'(~sck_q & serial_clk_i);
    end
  end
  // Age since the last raw rise saturates, so a stale edge never looks fresh.
  always_ff @(posedge clk_i) begin
    if (~sck_q & serial_clk_i) begin
      rise_age <= '0;
    end else if (rise_age != 4'hf) begin
      rise_age <= rise_age + 4'h1;
    end
    conv_cnt <= (state_o == ADFS_ST_CONV) ? conv_cnt + 16'h1 : 16'h0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_cs_starts_frame: assert property ($fell(chip_sel_n_i) && frame_sync_input_i |-> ##[2:6] state_o == ADFS_ST_SHIFT)
    else $error("chip-select fall did not start a frame");
  a_fs_starts_frame: assert property ($fell(frame_sync_input_i) && !chip_sel_n_i |-> ##[2:6] state_o == ADFS_ST_SHIFT)
    else $error("frame-sync fall did not start a frame");
  a_msb_on_rise: assert property ($rose(frame_sync_input_i) && !chip_sel_n_i |-> ##[2:6] !serial_data_out_oe_n_o)
    else $error("data output not driven after frame-sync rise");
  a_conv_after_falls: assert property (state_o == ADFS_ST_CONV && $past(state_o) == ADFS_ST_SHIFT |-> fall_cnt == 6'd24)
    else $error("conversion began at the wrong falling edge");
  a_pdown_auto: assert property ($past(state_o) == ADFS_ST_CONV && state_o == ADFS_ST_PDOWN
    |-> conv_cnt + 2 >= CONV_CYCLES ##[0:1] power_down_o) else $error("power down entry wrong");
  a_conv_bounded: assert property (state_o == ADFS_ST_CONV |-> conv_cnt <= CONV_CYCLES + 1)
    else $error("conversion overran its length");
  a_wake_on_edge: assert property (power_down_o && ($fell(chip_sel_n_i) || $rose(frame_sync_input_i))
    |-> ##[1:6] !power_down_o) else $error("no wake on frame edge");
  a_data_on_rise: assert property (!serial_data_out_oe_n_o && $past(!serial_data_out_oe_n_o)
    && $changed(serial_data_out_o) |-> rise_age inside {[1:7]}) else $error("data changed off a rising edge");
  a_release_count: assert property ($rose(serial_data_out_oe_n_o) && state_o == ADFS_ST_SHIFT
    |-> rise_cnt == 6'd17) else $error("data released after wrong bit count");
  c_cut: cover property ($past(state_o) == ADFS_ST_CONV && state_o == ADFS_ST_SHIFT);
  c_pdown: cover property ($rose(state_o == ADFS_ST_PDOWN));
  c_cs_frame: cover property ($fell(chip_sel_n_i) && frame_sync_input_i);
endmodule
bind adfs_frame_ctrl adfs_chk #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(serial_clk_i), .chip_sel_n_i(chip_sel_n_i),
  .frame_sync_input_i(frame_sync_input_i), .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe_n_o(serial_data_out_oe_n_o), .power_down_o(power_down_o), .state_o(state_o));

/* File: adfs_fifo.sv */
// Purpose : Small synchronous FIFO for sample words.
// Assumes : One clock, synchronous active-high reset.
// Notes   : Read data comes from a register; full and empty are exact.
`timescale 1ns/1ps
module adfs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // ****************************************************************
  // Handshake
  // ****************************************************************
  // The output register counts as one slot, so pop means the register reloads.
  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_valid_o && out_ready_i;

  // Storage write.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + AW'(1);
      end
      if (pop) begin
        rptr_reg <= rptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read port; a word is exposed once it is in memory.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_data_o  <= '0;
      out_valid_o <= 1'b0;
    end else if (!out_valid_o || out_ready_i) begin
      out_valid_o <= (count_reg != '0) && !(pop && count_reg == (AW+1)'(1));
      out_data_o  <= pop ? mem_reg[rptr_reg + AW'(1)] : mem_reg[rptr_reg];
    end
  end
endmodule

/* File: adfs_frame_ctrl.sv */
// Function
// - In chip-select mode a falling chip-select edge starts a new sample and conversion cycle at any clock level.
// - In frame-sync mode a rising frame-sync edge puts the result MSB on the serial data output.
// - In frame-sync mode a falling frame-sync edge starts the sampling cycle at any clock level.
// - Results are unipolar straight binary, 0000h at ground and FFFFh one step below reference.
// - Codes saturate at full scale at or above reference and at zero at or below ground.
// - The block enters low power by itself as soon as a conversion completes.
// - Low power ends on a chip-select fall or a frame-sync rise, whichever comes first.
// - The MSB is ready for the host to sample on the first falling clock edge after the frame start.
// - The serial data output changes only on rising serial clock edges.
// - Conversion of the held sample starts after the 24th falling clock edge of the frame.
// - A conversion cut short by a new frame gives FF00h in the following frame.
//
// Purpose : Frame control of a 16-bit sampling converter read by a DSP serial port.
// Assumes : Link pins are asynchronous and sampled by clk_i; analog result arrives as a signed word.
// Notes   : Sampled analog words queue in a FIFO; the converter core pops one per frame.
`timescale 1ns/1ps
`include "adfs_regs.svh"
module adfs_frame_ctrl #(
  parameter int CONV_CYCLES = `ADFS_CONV_CYCLES,
  parameter int FIFO_DEPTH  = `ADFS_FIFO_DEPTH
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      serial_clk_i,
  input  wire logic                      chip_sel_n_i,
  input  wire logic                      frame_sync_input_i,
  input  wire logic signed [17:0]        analog_word_i,
  input  wire logic                      analog_valid_i,
  output logic                           analog_ready_o,
  output logic                           serial_data_out_o,
  output logic                           serial_data_out_oe_n_o,
  output logic                           power_down_o,
  output adfs_pkg::adfs_state_t          state_o
);
  import adfs_pkg::*;

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [4:0] FALLS = 5'(`ADFS_FRAME_FALLS);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] fs_sync_reg;
  logic       sclk_d_reg;
  logic       cs_d_reg;
  logic       fs_d_reg;

  // Two flops per pin; only the second stage and its delayed copy are read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg   <= 2'h3;
      fs_sync_reg   <= 2'h3;
      sclk_d_reg    <= 1'b0;
      cs_d_reg      <= 1'b1;
      fs_d_reg      <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], serial_clk_i};
      cs_sync_reg   <= {cs_sync_reg[0], chip_sel_n_i};
      fs_sync_reg   <= {fs_sync_reg[0], frame_sync_input_i};
      sclk_d_reg    <= sclk_sync_reg[1];
      cs_d_reg      <= cs_sync_reg[1];
      fs_d_reg      <= fs_sync_reg[1];
    end
  end

  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       fs_rise;
  logic       fs_fall;
  logic       cs_low;
  logic [1:0] arm_reg;
  logic       armed;

  // The delayed copies hold real pin levels only three clocks after reset, so edges wait until then.
  // A pin idling low would otherwise look like a falling edge and open a false frame.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_reg <= 2'h0;
    end else if (arm_reg != 2'h3) begin
      arm_reg <= arm_reg + 2'h1;
    end
  end

  assign armed = (arm_reg == 2'h3);

  // Edge detection on the synchronised pins.
  assign sclk_rise = armed && sclk_sync_reg[1] && !sclk_d_reg;
  assign sclk_fall = armed && !sclk_sync_reg[1] && sclk_d_reg;
  assign cs_fall   = armed && !cs_sync_reg[1] && cs_d_reg;
  assign fs_rise   = armed && fs_sync_reg[1] && !fs_d_reg;
  assign fs_fall   = armed && !fs_sync_reg[1] && fs_d_reg;
  assign cs_low    = !cs_sync_reg[1];

  // ****************************************************************
  // Code conversion
  // ****************************************************************
  // Clamp a signed analog word to the unipolar 16-bit range.
  function automatic logic [15:0] adfs_clamp(input logic signed [17:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v < 18'sh0) begin
      r = `ADFS_CODE_ZERO;
    end else if (v > 18'sh0ffff) begin
      r = `ADFS_CODE_FULL;
    end
    return r;
  endfunction

  logic [15:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  // Input words wait here until a frame takes its sample.
  adfs_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (adfs_clamp(analog_word_i)),
    .in_valid_i  (analog_valid_i),
    .in_ready_o  (analog_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // ****************************************************************
  // Frame control
  // ****************************************************************
  adfs_state_t state_reg;
  adfs_mode_t  mode_reg;
  logic [4:0]  fall_cnt_reg;
  logic [CW-1:0] conv_cnt_reg;
  logic [15:0] sample_reg;
  logic [15:0] result_reg;
  logic [15:0] shift_reg;
  logic [4:0]  bit_cnt_reg;
  logic        frame_start;
  logic        conv_done;
  logic        conv_cut;

  // A frame starts on a chip-select fall (with frame-sync high) or a frame-sync fall (with chip-select low).
  // chip-select fall starts.
  assign frame_start = (cs_fall && fs_sync_reg[1]) || (fs_fall && cs_low);
  assign conv_done   = (state_reg == ADFS_ST_CONV) && (conv_cnt_reg == CW'(1));
  assign conv_cut    = (state_reg == ADFS_ST_CONV) && frame_start;
  // The held sample is captured as the frame begins.
  assign fifo_pop    = frame_start && fifo_valid;

  // Mode is fixed by which pin opened the frame.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= ADFS_MODE_CS;
    end else if (frame_start) begin
      mode_reg <= fs_fall ? ADFS_MODE_FS : ADFS_MODE_CS;
    end
  end

  // Sequencer: idle, shifting for 24 falls, converting, then power-down.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ADFS_ST_IDLE;
      fall_cnt_reg <= 5'h00;
      conv_cnt_reg <= '0;
    end else if (frame_start) begin
      state_reg    <= ADFS_ST_SHIFT;
      fall_cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        ADFS_ST_IDLE, ADFS_ST_PDOWN: begin
          state_reg <= state_reg;
        end
        ADFS_ST_SHIFT: begin
          if (sclk_fall) begin
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
            if (fall_cnt_reg == FALLS - 5'h01) begin
              state_reg    <= ADFS_ST_CONV;
              conv_cnt_reg <= CW'(CONV_CYCLES);
            end
          end
        end
        ADFS_ST_CONV: begin
          conv_cnt_reg <= conv_cnt_reg - CW'(1);
          if (conv_done) begin
            state_reg <= ADFS_ST_PDOWN;
          end
        end
      endcase
    end
  end

  // Sample holder: taken at frame start, converted while in the conversion state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_reg <= `ADFS_CODE_ZERO;
    end else if (fifo_pop) begin
      sample_reg <= fifo_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= `ADFS_CODE_CUT;
    end else if (conv_done) begin
      result_reg <= sample_reg;
    end else if (conv_cut) begin
      result_reg <= `ADFS_CODE_CUT;
    end
  end

  logic load_word;

  // wake on chip-select fall or frame-sync rise.
  // A word also loads at a chip-select frame start, as there is no frame-sync rise then.
  assign load_word = (fs_rise && cs_low) || (cs_fall && fs_sync_reg[1]);

  // Output shifter. The cut code is not yet in result_reg when loading,
  // so the loaded value picks it directly when a conversion is being cut.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_reg   <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end else if (load_word) begin
      shift_reg   <= (state_reg == ADFS_ST_CONV) ? `ADFS_CODE_CUT : result_reg;
      bit_cnt_reg <= 5'h10;
    end else if (sclk_rise && !frame_start && bit_cnt_reg != 5'h00 && state_reg == ADFS_ST_SHIFT
                 && fall_cnt_reg != 5'h00) begin
      shift_reg   <= {shift_reg[14:0], 1'b0};
      bit_cnt_reg <= bit_cnt_reg - 5'h01;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic awake_reg;

  // stay awake from the wake edge until the conversion ends.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awake_reg <= 1'b0;
    end else if (load_word) begin
      awake_reg <= 1'b1;
    end else if (conv_done) begin
      awake_reg <= 1'b0;
    end
  end

  // Data comes straight from the shifter; released after the sixteenth bit or chip-select high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_data_out_o      <= 1'b0;
      serial_data_out_oe_n_o <= 1'b1;
      power_down_o           <= 1'b1;
    end else begin
      serial_data_out_o      <= shift_reg[15];
      serial_data_out_oe_n_o <= !(cs_low && bit_cnt_reg != 5'h00);
      power_down_o           <= (state_reg == ADFS_ST_PDOWN || state_reg == ADFS_ST_IDLE)
                                && !load_word && !frame_start && !awake_reg;
    end
  end

  assign state_o = state_reg;
endmodule

/* File: adfs_host_model.sv */
// Purpose : Host serial port that frames and reads the converter.
// Assumes : Called at a falling edge of clk_i; link clock 160 ns.
// Notes   : Link clock stands low between frames.
`timescale 1ns/1ps
module adfs_host_model (
  input  wire logic clk_i,
  input  wire logic serial_data_out_i,
  input  wire logic serial_data_out_oe_n_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      fs_o
);
  logic last_bit = 1'b0;
  // A released line shows the inverse of its last value, never a lucky match.
  wire logic line = serial_data_out_oe_n_i ? ~last_bit : serial_data_out_i;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    fs_o = 1'b0;
  end
  always_ff @(posedge clk_i) begin
    if (!serial_data_out_oe_n_i) last_bit <= serial_data_out_i;
  end
  task automatic to_cs_mode();
    fs_o = 1'b1;
    repeat (8) @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic run_frame(input logic cs_mode, input int gap, output logic [15:0] word);
    word = 16'h0000;
    if (cs_mode) begin
      cs_n_o = 1'b0;
    end else begin
      fs_o = 1'b1;
      repeat (8) @(negedge clk_i);
      fs_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < 24; i++) begin
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (4) @(negedge clk_i);
      if (i < 16) word = {word[14:0], line};
    end
    if (cs_mode) cs_n_o = 1'b1;
    repeat (gap) @(negedge clk_i);
  endtask
endmodule

/* File: adfs_pkg.sv */
// Purpose : Types shared by the converter frame serial control files.
// Assumes : Constants come from adfs_regs.svh.
// Notes   : Types only.
package adfs_pkg;

  // Frame control states.
  typedef enum logic [1:0] {
    ADFS_ST_IDLE,
    ADFS_ST_SHIFT,
    ADFS_ST_CONV,
    ADFS_ST_PDOWN
  } adfs_state_t;

  // Control mode of the frame.
  typedef enum logic {
    ADFS_MODE_CS,
    ADFS_MODE_FS
  } adfs_mode_t;

endpackage

/* File: adfs_regs.svh */
// Purpose : Constants for the converter frame serial control block.
// Assumes : 50 MHz system clock; link clock sampled, never used as a clock.
// Notes   : Result width, codes and timing counts live here.
`ifndef ADFS_REGS_SVH
`define ADFS_REGS_SVH

// ****************************************************************
// Frame and code constants
// ****************************************************************
`define ADFS_RESULT_W        16
`define ADFS_FRAME_FALLS     24
`define ADFS_CODE_ZERO       16'h0000
`define ADFS_CODE_FULL       16'hffff
`define ADFS_CODE_CUT        16'hff00
`define ADFS_FIFO_DEPTH      16

// ****************************************************************
// Timing
// ****************************************************************
`define ADFS_CLK_MHZ         50
`define ADFS_CONV_TIME_NS    2940
`define ADFS_CONV_CYCLES     ((`ADFS_CONV_TIME_NS * `ADFS_CLK_MHZ + 999) / 1000)

`endif

/* File: tb.sv */
// Purpose : Self-checking bench for the frame serial control block.
// Assumes : Short conversion count; host model owns the link pins.
// Notes   : Expected words come from the bench's own clamp.
`timescale 1ns/1ps
module tb;
  import adfs_pkg::*;
  localparam int CONV = 40;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic signed [17:0] word_i = '0;
  logic               valid_i = 1'b0;
  wire logic          sclk, cs_n, fs, ready, serial_data_out, oe_n, pdown;
  adfs_state_t        state;
  logic [15:0]        got;
  int                 failures = 0;
  int                 compares = 0;
  initial forever #10 clk_i = ~clk_i;
  adfs_frame_ctrl #(.CONV_CYCLES(CONV), .FIFO_DEPTH(16)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk), .chip_sel_n_i(cs_n),
    .frame_sync_input_i(fs), .analog_word_i(word_i), .analog_valid_i(valid_i),
    .analog_ready_o(ready), .serial_data_out_o(serial_data_out), .serial_data_out_oe_n_o(oe_n),
    .power_down_o(pdown), .state_o(state));
  adfs_host_model host_u (.clk_i(clk_i), .serial_data_out_i(serial_data_out), .serial_data_out_oe_n_i(oe_n),
    .sclk_o(sclk), .cs_n_o(cs_n), .fs_o(fs));
  function automatic logic signed [17:0] sample(input int i);
    case (i)
      0: return -18'sd5;
      1: return 18'sh0ffff;
      2: return 18'sh12345;
      3: return 18'sh00000;
      default: return 18'(i * 18'h00b35 + 18'h000a5);
    endcase
  endfunction
  // Out-of-range inputs pin to the ends of the code range.
  function automatic logic [15:0] clamp(input logic signed [17:0] w);
    if (w < 0) return 16'h0000;
    if (w > 18'sh0ffff) return 16'hffff;
    return w[15:0];
  endfunction
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_word({15'h0, g}, {15'h0, e});
  endtask
  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Valid is left high between pushes; the caller drops it.
  task automatic push(input logic signed [17:0] w);
    int n;
    word_i = w;
    valid_i = 1'b1;
    for (n = 0; n < 50 && ready !== 1'b1; n++) @(negedge clk_i);
    if (n == 50) begin
      failures++;
      end_sim();
    end
    @(negedge clk_i);
  endtask
  // Fill the buffer until it refuses, then drain it frame by frame.
  task automatic t_stream();
    for (int i = 0; i < 16; i++) push(sample(i));
    word_i = sample(16);
    repeat (2) @(negedge clk_i);
    chk_bit(ready, 1'b0);
    valid_i = 1'b0;
    host_u.run_frame(1'b0, 80, got);
    chk_word(got, 16'hff00);
    for (int k = 1; k < 17; k++) begin
      host_u.run_frame(1'b0, 80, got);
      chk_word(got, clamp(sample(k - 1)));
      chk_bit(pdown, 1'b1);
    end
    $display("test stream done");
  endtask
  // A frame begun mid-conversion yields the cut code, then recovers.
  task automatic t_cut();
    for (int i = 16; i < 19; i++) push(sample(i));
    valid_i = 1'b0;
    host_u.run_frame(1'b0, 0, got);
    host_u.run_frame(1'b0, 80, got);
    chk_word(got, 16'hff00);
    host_u.run_frame(1'b0, 80, got);
    chk_word(got, clamp(sample(17)));
    $display("test cut done");
  endtask
  // Chip-select framing with frame-sync held high.
  task automatic t_cs();
    push(sample(19));
    valid_i = 1'b0;
    host_u.to_cs_mode();
    chk_bit(oe_n, 1'b1);
    host_u.run_frame(1'b1, 80, got);
    chk_word(got, clamp(sample(18)));
    chk_bit(state === ADFS_ST_PDOWN, 1'b1);
    host_u.run_frame(1'b1, 80, got);
    chk_word(got, clamp(sample(19)));
    $display("test cs done");
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk_bit(pdown, 1'b1);
    t_stream();
    t_cut();
    t_cs();
    end_sim();
  end
endmodule
